//--- rtl/slip_comp_pkg.sv
`default_nettype none
package slip_comp_pkg;

  // ****************************************************************
  // Register map (byte addresses on APB).
  // ****************************************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_GAIN = 8'h04;
  localparam logic [7:0] ADDR_DELAY = 8'h08;
  localparam logic [7:0] ADDR_LIMIT = 8'h0C;
  localparam logic [7:0] ADDR_RATED_SLIP = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_CORRECTION = 8'h18;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_REGEN_BIT = 1;
  localparam int CTRL_VSAT_BIT = 2;
  localparam int CTRL_OLV_BIT = 3;
  localparam int CTRL_LOAD_DEFAULTS_BIT = 4;

  // ****************************************************************
  // Scaling and defaults. Gain in tenths, slip in 0.01 Hz units,
  // torque ratio in 1/256 of rated torque, limit in percent.
  // ****************************************************************
  localparam logic [7:0] GAIN_DEFAULT_VF = 8'h00;
  localparam logic [7:0] GAIN_DEFAULT_OLV = 8'h0A;
  localparam logic [7:0] GAIN_ONE = 8'h0A;
  localparam logic [13:0] DELAY_MAX_MS = 14'h2710;
  localparam logic [13:0] DELAY_DEFAULT_VF_MS = 14'h07D0;
  localparam logic [13:0] DELAY_DEFAULT_OLV_MS = 14'h00C8;
  localparam logic [7:0] LIMIT_MAX_PCT = 8'hFA;
  localparam logic [7:0] LIMIT_DEFAULT_PCT = 8'hC8;
  localparam logic [15:0] RATED_SLIP_DEFAULT = 16'h00C8;
  localparam logic [8:0] TORQUE_RATED = 9'h100;
  localparam int CLOCK_HZ = 10_000_000;
  localparam int MS_NS = 1_000_000;
  localparam int CLOCK_PERIOD_NS = 1_000_000_000 / CLOCK_HZ;
  localparam int CYCLES_PER_MS = MS_NS / CLOCK_PERIOD_NS;

  // Configuration bundle passed to the datapath.
  typedef struct packed {
    logic enable;
    logic regen_slip_select;
    logic voltage_saturation_select;
    logic [7:0] slip_gain_setting;
    logic [13:0] slip_delay_setting;
    logic [7:0] slip_limit_setting;
    logic [15:0] motor_rated_slip_setting;
  } config_type;

  // Per-cycle drive measurements.
  typedef struct packed {
    logic signed [9:0] torque_ratio;
    logic regenerating;
    logic [15:0] output_voltage_command_monitor;
    logic [15:0] input_voltage;
  } drive_type;

endpackage
`default_nettype wire

//--- rtl/slip_lag_filter.sv
`timescale 1ns/100ps
`default_nettype none
module slip_lag_filter (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Filter control.
  input wire logic sample,
  input wire logic [13:0] delay_ms,
  // Data.
  input wire logic signed [23:0] target,
  output logic signed [23:0] filtered
);

  // ****************************************************************
  // First-order lag, one update per millisecond tick.
  // ****************************************************************
  logic signed [31:0] acc;
  logic signed [31:0] next_acc;
  logic signed [31:0] err;

  // Step the accumulator by error divided by the time constant.
  always_comb begin
    err = 32'(target) - (acc >>> 8);
    next_acc = acc;
    if (sample) begin
      if (delay_ms == 14'h0000) begin
        next_acc = {target, 8'h00};
      end else begin
        next_acc = acc + ((err <<< 8) / $signed({18'h00000, delay_ms}));
      end
    end
  end

  // Register the accumulator.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= 32'sh00000000;
    end else begin
      acc <= next_acc;
    end
  end

  assign filtered = acc[31:8];

endmodule
`default_nettype wire

//--- rtl/slip_compensation.sv
// Operation
// - At rated load add rated slip times gain to output frequency.
// - Default gain is 0.0 in V/f and 1.0 in open loop vector.
// - Gain 0.0 applies no slip correction.
// - Gain 1.0 scales correction by actual torque, rated slip as reference.
// - Lag the correction by a millisecond constant up to 10000; default 2000/200.
// - Clamp correction to a percentage of rated slip, up to 250, default 200.
// - Regeneration select 0 suppresses correction while regenerating, 1 allows it.
// - Voltage saturation select 1 lowers motor flux once output saturates.
// - Saturated means commanded voltage exceeds input voltage; then reduce voltage.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module slip_compensation (
  // APB clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive measurements from the same clock domain.
  input wire slip_comp_pkg::drive_type drive,
  input wire logic [15:0] base_frequency,
  // Results.
  output logic [15:0] output_frequency,
  output logic [15:0] voltage_command,
  output logic flux_reduce,
  output logic voltage_saturated
);
  import slip_comp_pkg::*;

  // ****************************************************************
  // Register file.
  // ****************************************************************
  config_type cfg;
  config_type next_cfg;
  logic olv_mode;
  logic next_olv_mode;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic access;
  logic setup_phase;
  logic signed [23:0] correction;

  // Saturating loads keep settings within their documented ranges.
  function automatic logic [13:0] clip_delay(input logic [31:0] v);
    clip_delay = (v > {18'h00000, DELAY_MAX_MS}) ? DELAY_MAX_MS : v[13:0];
  endfunction

  function automatic logic [7:0] clip_limit(input logic [31:0] v);
    clip_limit = (v > {24'h000000, LIMIT_MAX_PCT}) ? LIMIT_MAX_PCT : v[7:0];
  endfunction

  // Only the setting registers take writes; status and correction are read-only.
  function automatic logic is_writable(input logic [7:0] a);
    is_writable = (a == ADDR_CONTROL) || (a == ADDR_GAIN) || (a == ADDR_DELAY)
                  || (a == ADDR_LIMIT) || (a == ADDR_RATED_SLIP);
  endfunction

  assign access = psel && penable;
  assign setup_phase = psel && !penable;

  // Writes land at the edge that ends the access phase. The read answer and the
  // error flag are registered at the setup edge, so with pready always high they
  // already stand at the edge where the master samples them.
  // Defaults loaded through the control word follow the selected control method.
  always_comb begin
    next_cfg = cfg;
    next_olv_mode = olv_mode;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (access && pwrite) begin
      case (paddr)
        ADDR_CONTROL: begin
          next_cfg.enable = pwdata[CTRL_ENABLE_BIT];
          next_cfg.regen_slip_select = pwdata[CTRL_REGEN_BIT];
          next_cfg.voltage_saturation_select = pwdata[CTRL_VSAT_BIT];
          next_olv_mode = pwdata[CTRL_OLV_BIT];
          if (pwdata[CTRL_LOAD_DEFAULTS_BIT]) begin
            next_cfg.slip_gain_setting = pwdata[CTRL_OLV_BIT] ? GAIN_DEFAULT_OLV
                                                              : GAIN_DEFAULT_VF;
            next_cfg.slip_delay_setting = pwdata[CTRL_OLV_BIT] ? DELAY_DEFAULT_OLV_MS
                                                               : DELAY_DEFAULT_VF_MS;
          end
        end
        ADDR_GAIN: next_cfg.slip_gain_setting = pwdata[7:0];
        ADDR_DELAY: next_cfg.slip_delay_setting = clip_delay(pwdata);
        ADDR_LIMIT: next_cfg.slip_limit_setting = clip_limit(pwdata);
        ADDR_RATED_SLIP: next_cfg.motor_rated_slip_setting = pwdata[15:0];
        default: next_cfg = cfg;
      endcase
    end
    if (setup_phase && pwrite) begin
      next_pslverr = !is_writable(paddr);
    end else if (setup_phase) begin
      case (paddr)
        ADDR_CONTROL: next_prdata = {28'h0000000, olv_mode, cfg.voltage_saturation_select,
                                     cfg.regen_slip_select, cfg.enable};
        ADDR_GAIN: next_prdata = {24'h000000, cfg.slip_gain_setting};
        ADDR_DELAY: next_prdata = {18'h00000, cfg.slip_delay_setting};
        ADDR_LIMIT: next_prdata = {24'h000000, cfg.slip_limit_setting};
        ADDR_RATED_SLIP: next_prdata = {16'h0000, cfg.motor_rated_slip_setting};
        ADDR_STATUS: next_prdata = {30'h00000000, flux_reduce, voltage_saturated};
        ADDR_CORRECTION: next_prdata = {{8{correction[23]}}, correction};
        default: begin
          next_prdata = 32'h00000000;
          next_pslverr = 1'b1;
        end
      endcase
    end
  end

  // Register the configuration and bus answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '{enable: 1'b1, regen_slip_select: 1'b0, voltage_saturation_select: 1'b0,
               slip_gain_setting: GAIN_DEFAULT_VF, slip_delay_setting: DELAY_DEFAULT_VF_MS,
               slip_limit_setting: LIMIT_DEFAULT_PCT,
               motor_rated_slip_setting: RATED_SLIP_DEFAULT};
      olv_mode <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      cfg <= next_cfg;
      olv_mode <= next_olv_mode;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      pready <= 1'b1;
    end
  end

  // ****************************************************************
  // Correction datapath.
  // ****************************************************************
  logic [13:0] ms_count;
  logic [13:0] next_ms_count;
  logic ms_tick;
  logic next_ms_tick;
  logic signed [23:0] raw;
  logic signed [23:0] clamp_hi;
  logic signed [35:0] product;
  logic signed [23:0] lagged;
  logic signed [23:0] next_correction;
  logic [15:0] next_output_frequency;
  logic [15:0] next_voltage_command;
  logic next_flux_reduce;
  logic next_voltage_saturated;
  logic allow;

  // Millisecond tick paces the lag filter.
  always_comb begin
    next_ms_tick = (ms_count == 14'(CYCLES_PER_MS - 1));
    next_ms_count = next_ms_tick ? 14'h0000 : ms_count + 14'h0001;
  end

  // Raw correction: gain (tenths) x slip x torque ratio / 256 / 10.
  always_comb begin
    product = $signed({1'b0, cfg.slip_gain_setting}) * $signed({1'b0, cfg.motor_rated_slip_setting})
              * drive.torque_ratio;
    allow = cfg.enable && (cfg.slip_gain_setting != 8'h00)
            && (!drive.regenerating || cfg.regen_slip_select);
    raw = allow ? 24'((product >>> 8) / 36'sd10) : 24'sh000000;
  end

  slip_lag_filter lag (
    .pclk(pclk),
    .presetn(presetn),
    .sample(ms_tick),
    .delay_ms(cfg.slip_delay_setting),
    .target(raw),
    .filtered(lagged)
  );

  // Clamp, apply, and handle output voltage saturation.
  always_comb begin
    clamp_hi = 24'(({8'h00, cfg.motor_rated_slip_setting} * {16'h0000, cfg.slip_limit_setting})
               / 24'd100);
    if (lagged > clamp_hi) begin
      next_correction = clamp_hi;
    end else if (lagged < -clamp_hi) begin
      next_correction = -clamp_hi;
    end else begin
      next_correction = lagged;
    end
    next_output_frequency = 16'($signed({8'h00, base_frequency}) + next_correction);
    next_voltage_saturated = drive.output_voltage_command_monitor > drive.input_voltage;
    next_flux_reduce = next_voltage_saturated && cfg.voltage_saturation_select;
    next_voltage_command = next_flux_reduce ? drive.input_voltage
                                            : drive.output_voltage_command_monitor;
  end

  // Register all datapath state and outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_count <= 14'h0000;
      ms_tick <= 1'b0;
      correction <= 24'sh000000;
      output_frequency <= 16'h0000;
      voltage_command <= 16'h0000;
      flux_reduce <= 1'b0;
      voltage_saturated <= 1'b0;
    end else begin
      ms_count <= next_ms_count;
      ms_tick <= next_ms_tick;
      correction <= next_correction;
      output_frequency <= next_output_frequency;
      voltage_command <= next_voltage_command;
      flux_reduce <= next_flux_reduce;
      voltage_saturated <= next_voltage_saturated;
    end
  end

endmodule
`default_nettype wire

//--- tb/motor_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Motor side.
// ****
module motor_model (
  // Clock.
  input wire logic pclk,
  // Load knobs from the bench.
  input wire logic signed [9:0] load,
  input wire logic regen,
  input wire logic [15:0] volts,
  // Measurements.
  output var slip_comp_pkg::drive_type drive
);
  // Measurements lag the knobs by one cycle, and the supply stays at a fixed level.
  always_ff @(posedge pclk) begin
    drive <= '{load, regen, volts, 16'h0190};
  end
endmodule
`default_nettype wire

//--- tb/slip_comp_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Port checks.
// ****
module slip_comp_sva (
  // Bus.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Drive.
  input wire slip_comp_pkg::drive_type drive,
  input wire logic [15:0] voltage_command,
  input wire logic flux_reduce,
  input wire logic voltage_saturated
);
  import slip_comp_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Short names for watched terms.
  wire logic [15:0] vcmd = drive.output_voltage_command_monitor;
  wire logic setup_phase = psel && !penable;
  chk_sat_flag: assert property ($past(presetn) |->
    voltage_saturated == $past(vcmd > drive.input_voltage)) else $error("bad saturation flag");
  chk_flux_sat: assert property (flux_reduce |-> voltage_saturated)
    else $error("flux cut while unsaturated");
  chk_vcmd_pass: assert property ($past(presetn) && !flux_reduce |->
    voltage_command == $past(vcmd)) else $error("voltage not passed");
  chk_vcmd_clamp: assert property (flux_reduce |->
    voltage_command == $past(drive.input_voltage)) else $error("voltage not limited");
  chk_ready_high: assert property ($past(presetn) |-> pready) else $error("ready low");
  chk_err_cause: assert property (pslverr |-> $past(setup_phase)) else $error("stray error");
  chk_rdata_hold: assert property ($past(presetn) && !$past(setup_phase && !pwrite)
    |-> $stable(prdata)) else $error("read data moved");
  chk_status_read: assert property ($past(presetn) && $past(setup_phase && !pwrite &&
    paddr == ADDR_STATUS) |-> prdata == {30'h0, $past(flux_reduce), $past(voltage_saturated)})
    else $error("bad status");
  cover property ($rose(flux_reduce));
  cover property ($rose(voltage_saturated));
  cover property (pslverr);
endmodule
bind slip_compensation slip_comp_sva chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .drive, .voltage_command, .flux_reduce, .voltage_saturated);
`default_nettype wire

//--- tb/slip_compensation_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Bench.
// ****
module slip_compensation_tb;
  import slip_comp_pkg::*;
  typedef struct {
    logic [7:0] gain, limit;
    logic signed [9:0] torque;
    logic rg, sel;
    logic [15:0] corr;
  } row_type;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, regen = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [15:0] base_frequency = 16'h1388, volts = 16'h0064, output_frequency, voltage_command;
  logic signed [9:0] load = 10'sh000;
  logic pready, pslverr, flux_reduce, voltage_saturated, err;
  drive_type drive;
  int err_total = 0, checks = 0, n;
  row_type rows [7] = '{
    '{8'h0A, 8'hC8, 10'sh100, 1'b0, 1'b0, 16'h00C8},
    '{8'h0A, 8'hC8, 10'sh080, 1'b0, 1'b0, 16'h0064},
    '{8'h00, 8'hC8, 10'sh100, 1'b0, 1'b0, 16'h0000},
    '{8'h19, 8'hC8, 10'sh100, 1'b0, 1'b0, 16'h0190},
    '{8'h1A, 8'hFF, 10'sh100, 1'b0, 1'b0, 16'h01F4},
    '{8'h0A, 8'hC8, 10'sh100, 1'b1, 1'b0, 16'h0000},
    '{8'h0A, 8'hC8, 10'sh100, 1'b1, 1'b1, 16'h00C8}};
  // Clock at 100 ns.
  always #50 pclk = ~pclk;
  slip_compensation uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .drive, .base_frequency, .output_frequency, .voltage_command,
    .flux_reduce, .voltage_saturated);
  motor_model motor (.pclk, .load, .regen, .volts, .drive);
  // Compares and counts.
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  // Prints the verdict and stops.
  task conclude;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One bus transfer; read data and error are taken at the edge that ends the access.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      conclude;
    end
    @(posedge pclk);
  endtask
  // Waits for the frequency to reach its target.
  task settle(input logic [15:0] exp);
    n = 0;
    while (output_frequency !== exp && n < 11000) begin
      @(posedge pclk);
      n++;
    end
    check(output_frequency, exp);
    if (n == 11000) conclude;
  endtask
  // Main sequence.
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, ADDR_CONTROL, 0); check(rd, 32'h1);
    apb(0, ADDR_GAIN, 0); check(rd, GAIN_DEFAULT_VF);
    apb(0, ADDR_DELAY, 0); check(rd, DELAY_DEFAULT_VF_MS);
    apb(0, ADDR_LIMIT, 0); check(rd, LIMIT_DEFAULT_PCT);
    load <= 10'sh100;
    settle(16'h1388);
    apb(1, ADDR_CONTROL, 32'h19);
    apb(0, ADDR_GAIN, 0); check(rd, 32'h0A);
    apb(0, ADDR_DELAY, 0); check(rd, 32'hC8);
    apb(1, ADDR_DELAY, 32'h3000);
    apb(0, ADDR_DELAY, 0); check(rd, 32'h2710);
    apb(0, 8'h1C, 0); check(err, 1'b1);
    apb(1, ADDR_STATUS, 0); check(err, 1'b1);
    apb(1, ADDR_RATED_SLIP, 32'h1388 - 32'h5A0 * 32'h4 * 32'h64 / 32'h78);
    apb(1, ADDR_DELAY, 0);
    $display("setup tests done");
    foreach (rows[i]) begin
      apb(1, ADDR_CONTROL, {30'h0, rows[i].sel, 1'b1});
      apb(1, ADDR_GAIN, rows[i].gain);
      apb(1, ADDR_LIMIT, rows[i].limit);
      load <= rows[i].torque;
      regen <= rows[i].rg;
      settle(16'h1388 + rows[i].corr);
      $display("row %0d done", i);
    end
    // A 5 ms lag moves one fifth of the way towards a new target per millisecond.
    regen <= 1'b0;
    apb(1, ADDR_DELAY, 32'h5);
    apb(1, ADDR_GAIN, 0);
    n = 0;
    while (output_frequency === 16'h1450 && n < 11000) begin
      @(posedge pclk);
      n++;
    end
    check(output_frequency, 16'h1428);
    if (n == 11000) conclude;
    apb(0, ADDR_CORRECTION, 0);
    check(rd, 32'h000000A0);
    volts <= 16'h01F4;
    repeat (3) @(posedge pclk);
    check(voltage_saturated, 1'b1);
    check(flux_reduce, 1'b0);
    check(voltage_command, 16'h01F4);
    apb(1, ADDR_CONTROL, 32'h5);
    repeat (2) @(posedge pclk);
    check(flux_reduce, 1'b1);
    check(voltage_command, 16'h0190);
    apb(0, ADDR_STATUS, 0); check(rd, 32'h3);
    $display("lag and voltage tests done");
    presetn <= 1'b0;
    @(posedge pclk) check(pready, 1'b0);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, ADDR_GAIN, 0); check(rd, GAIN_DEFAULT_VF);
    apb(0, ADDR_CONTROL, 0);
    check(rd, 32'h1);
    $display("reset test done");
    conclude;
  end
endmodule
`default_nettype wire
